//--- logic/bgcl_params.svh
// Offsets, reset values and field positions of the bridge general control bank
`ifndef BGCL_PARAMS_SVH
`define BGCL_PARAMS_SVH
`define BGCL_OFF_DEVCAP 12'h094
`define BGCL_OFF_GCTL 12'h0d4
`define BGCL_OFF_VRSV 12'h0d8
`define BGCL_OFF_AER 12'h100
`define BGCL_GCTL_RST 32'h8206c000
`define BGCL_VRSV_RST 8'h00
`define BGCL_VC_NEXT_ON 12'h150
`define BGCL_VC_NEXT_OFF 12'h000
`define BGCL_DEVCAP_SHALLOW_LSB 6
`define BGCL_DEVCAP_DEEP_LSB 9
`define BGCL_AER_NEXT_LSB 20
`define BGCL_GCTL_LOW_BITS 20
`define BGCL_SHALLOW_BASE_NS 17'd64
`define BGCL_DEEP_BASE_NS 17'd1000
`endif

//--- logic/bgcl_pkg.sv
// Types shared by the bridge general control bank
package bgcl_pkg;
  // Lower twenty bits of the general control register, msb first
  typedef struct packed {
    logic prefetch_inhibit;
    logic [2:0] shallow_idle_exit_budget;
    logic [2:0] deep_idle_exit_budget;
    logic virtual_channel_struct_on;
    logic d3_clock_stop;
    logic beacon_on;
    logic [1:0] min_power_scale;
    logic [7:0] min_power_amount;
  } bgcl_gctl_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } bgcl_cfg_req_s;

  typedef struct packed {
    logic [1:0] scale;
    logic [7:0] amount;
  } bgcl_power_s;
endpackage

//--- logic/bgcl_bank.sv
// General control low bank with reserved byte and mirrored capability fields
`timescale 1ns/1ps
`default_nettype none
`include "bgcl_params.svh"

module bgcl_bank import bgcl_pkg::*; (
  // Clock and power-on reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Reset pins, asynchronous to ref_clk
  input wire logic fund_reset_n,
  input wire logic global_reset_pin,
  // Configuration access
  input wire bgcl_cfg_req_s cfg_req,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  // Bridge side
  input wire logic in_d3,
  input wire logic l2_wake_req,
  output logic prefetch_inhibit,
  output logic sec_clk_run,
  output logic wake_out,
  output logic beacon_out,
  output var bgcl_power_s min_power,
  output logic [16:0] shallow_floor_ns,
  output logic [16:0] deep_floor_ns
);

  localparam logic [31:0] GCTL_RST = `BGCL_GCTL_RST;
  localparam bgcl_gctl_s GCTL_DEF = GCTL_RST[19:0];

  // Lower bound of a budget band; code 000 means below base, so floor is zero
  function automatic logic [16:0] band_floor(input logic [2:0] code, input logic [16:0] base);
    logic [16:0] f;
    f = 17'h0;
    if (code != 3'h0) begin
      f = base << (code - 3'h1);
    end
    return f;
  endfunction

  function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return m;
  endfunction

  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
    return {a[11:2], 2'b00} == off;
  endfunction

  // Reset pin synchronisers
  logic [2:0] fsync;
  logic [2:0] gsync;
  logic fund_ok;
  logic glob_on;
  logic [2:0] next_fsync;
  logic [2:0] next_gsync;
  logic next_fund_ok;
  logic next_glob_on;
  logic clr_soft;

  always_comb begin
    next_fsync = {fsync[1:0], fund_reset_n};
    next_gsync = {gsync[1:0], global_reset_pin};
    // A change counts only once the last two stages agree
    next_fund_ok = (fsync[2] == fsync[1]) ? fsync[1] : fund_ok;
    next_glob_on = (gsync[2] == gsync[1]) ? gsync[1] : glob_on;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fsync <= 3'h0;
      gsync <= 3'h0;
      fund_ok <= 1'b0;
      glob_on <= 1'b0;
    end else begin
      fsync <= next_fsync;
      gsync <= next_gsync;
      fund_ok <= next_fund_ok;
      glob_on <= next_glob_on;
    end
  end

  assign clr_soft = !fund_ok || glob_on;

  // Register state
  bgcl_gctl_s gctl;
  logic [7:0] vrsv;
  bgcl_gctl_s next_gctl;
  logic [7:0] next_vrsv;
  logic [31:0] merged;
  logic wr_gctl;
  logic wr_vrsv;

  assign wr_gctl = cfg_req.valid && cfg_req.write && addr_hit(cfg_req.addr, `BGCL_OFF_GCTL);
  assign wr_vrsv = cfg_req.valid && cfg_req.write && addr_hit(cfg_req.addr, `BGCL_OFF_VRSV);

  always_comb begin
    next_gctl = gctl;
    next_vrsv = vrsv;
    merged = 32'h0;
    if (clr_soft) begin
      // Reset wins over a write; sticky bits ride through on aux power
      next_gctl = GCTL_DEF;
      next_gctl.d3_clock_stop = gctl.d3_clock_stop;
      next_gctl.beacon_on = gctl.beacon_on;
      next_vrsv = `BGCL_VRSV_RST;
    end else begin
      if (wr_gctl) begin
        // Bits 31:20 belong to other logic and are not stored here
        merged = byte_merge({GCTL_RST[31:20], gctl}, cfg_req.wdata, cfg_req.be);
        next_gctl = merged[19:0];
      end
      if (wr_vrsv && cfg_req.be[0]) begin
        // Stored as written; keeping it at default is software's duty
        next_vrsv = cfg_req.wdata[7:0];
      end
    end
  end

  // Power-on reset is the only reset that clears the sticky bits
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gctl <= GCTL_DEF;
      vrsv <= `BGCL_VRSV_RST;
    end else begin
      gctl <= next_gctl;
      vrsv <= next_vrsv;
    end
  end

  // Read decode, taken straight from live state so a write shows on the next read
  logic [31:0] rd_word;
  logic [11:0] vc_next;

  always_comb begin
    vc_next = gctl.virtual_channel_struct_on ? `BGCL_VC_NEXT_ON : `BGCL_VC_NEXT_OFF;
    rd_word = 32'h0;
    if (addr_hit(cfg_req.addr, `BGCL_OFF_GCTL)) begin
      rd_word = {GCTL_RST[31:20], gctl};
    end else if (addr_hit(cfg_req.addr, `BGCL_OFF_VRSV)) begin
      rd_word = {24'h0, vrsv};
    end else if (addr_hit(cfg_req.addr, `BGCL_OFF_DEVCAP)) begin
      rd_word[`BGCL_DEVCAP_SHALLOW_LSB +: 3] = gctl.shallow_idle_exit_budget;
      rd_word[`BGCL_DEVCAP_DEEP_LSB +: 3] = gctl.deep_idle_exit_budget;
    end else if (addr_hit(cfg_req.addr, `BGCL_OFF_AER)) begin
      rd_word[`BGCL_AER_NEXT_LSB +: 12] = vc_next;
    end
  end

  // Access answer and bridge-side outputs
  logic next_cfg_ack;
  logic [31:0] next_cfg_rdata;
  logic next_prefetch_inhibit;
  logic next_sec_clk_run;
  logic next_wake_out;
  logic next_beacon_out;
  bgcl_power_s next_min_power;
  logic [16:0] next_shallow_floor_ns;
  logic [16:0] next_deep_floor_ns;

  always_comb begin
    next_cfg_ack = cfg_req.valid;
    next_cfg_rdata = (cfg_req.valid && !cfg_req.write) ? rd_word : 32'h0;
    next_prefetch_inhibit = gctl.prefetch_inhibit;
    next_sec_clk_run = !(in_d3 && gctl.d3_clock_stop);
    next_wake_out = l2_wake_req;
    next_beacon_out = l2_wake_req && gctl.beacon_on;
    next_min_power = {gctl.min_power_scale, gctl.min_power_amount};
    next_shallow_floor_ns = band_floor(gctl.shallow_idle_exit_budget, `BGCL_SHALLOW_BASE_NS);
    next_deep_floor_ns = band_floor(gctl.deep_idle_exit_budget, `BGCL_DEEP_BASE_NS);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_ack <= 1'b0;
      cfg_rdata <= 32'h0;
      prefetch_inhibit <= 1'b0;
      sec_clk_run <= 1'b1;
      wake_out <= 1'b0;
      beacon_out <= 1'b0;
      min_power <= '0;
      shallow_floor_ns <= 17'h0;
      deep_floor_ns <= 17'h0;
    end else begin
      cfg_ack <= next_cfg_ack;
      cfg_rdata <= next_cfg_rdata;
      prefetch_inhibit <= next_prefetch_inhibit;
      sec_clk_run <= next_sec_clk_run;
      wake_out <= next_wake_out;
      beacon_out <= next_beacon_out;
      min_power <= next_min_power;
      shallow_floor_ns <= next_shallow_floor_ns;
      deep_floor_ns <= next_deep_floor_ns;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence wr_shallow_s;
    cfg_req.valid && cfg_req.write && cfg_req.be[2] && !clr_soft
      && addr_hit(cfg_req.addr, `BGCL_OFF_GCTL);
  endsequence

  sequence rd_devcap_s;
    cfg_req.valid && !cfg_req.write && addr_hit(cfg_req.addr, `BGCL_OFF_DEVCAP);
  endsequence

  mirror_next_read_a: assert property (
    wr_shallow_s ##1 rd_devcap_s |=> cfg_rdata[8:6] == $past(cfg_req.wdata[18:16], 2))
    else $error("shallow budget not mirrored on next read");

  deep_mirror_a: assert property (
    rd_devcap_s |=> cfg_rdata[11:9] == $past(gctl.deep_idle_exit_budget)
      && cfg_rdata[5:0] == 6'h0)
    else $error("deep budget mirror wrong");

  vc_offset_a: assert property (
    cfg_req.valid && !cfg_req.write && addr_hit(cfg_req.addr, `BGCL_OFF_AER)
      |=> cfg_rdata[31:20] == ($past(gctl.virtual_channel_struct_on) ? 12'h150 : 12'h000))
    else $error("next capability offset wrong");

  gctl_upper_a: assert property (
    cfg_req.valid && !cfg_req.write && addr_hit(cfg_req.addr, `BGCL_OFF_GCTL)
      |=> cfg_rdata[31:20] == 12'h820 && cfg_ack)
    else $error("control register upper bits wrong");

  soft_clear_a: assert property (
    clr_soft |=> gctl.shallow_idle_exit_budget == 3'b110 && gctl.deep_idle_exit_budget == 3'b110
      && gctl.min_power_amount == 8'h00 && !gctl.prefetch_inhibit)
    else $error("non-sticky fields not cleared");

  sticky_hold_a: assert property (
    clr_soft |=> $stable(gctl.d3_clock_stop) && $stable(gctl.beacon_on))
    else $error("sticky bit lost on reset");

  vrsv_clear_a: assert property (
    clr_soft |=> vrsv == 8'h00)
    else $error("reserved byte not cleared");

  clock_stop_a: assert property (
    in_d3 && gctl.d3_clock_stop |=> !sec_clk_run)
    else $error("secondary clocks not stopped in D3");

  beacon_use_a: assert property (
    l2_wake_req |=> wake_out && (beacon_out == $past(gctl.beacon_on)))
    else $error("wake mechanism wrong");

  prefetch_mode_a: assert property (
    ##1 prefetch_inhibit == $past(gctl.prefetch_inhibit))
    else $error("prefetch mode not followed");

  band_floor_a: assert property (
    gctl.shallow_idle_exit_budget == 3'b110 && gctl.deep_idle_exit_budget == 3'b110
      |=> shallow_floor_ns == 17'd2048 && deep_floor_ns == 17'd32000)
    else $error("budget band floor wrong");

  power_scale_a: assert property (
    ##1 min_power.scale == $past(gctl.min_power_scale)
      && min_power.amount == $past(gctl.min_power_amount))
    else $error("power scale output wrong");

  ack_pulse_a: assert property (
    cfg_req.valid |=> cfg_ack)
    else $error("access not acknowledged");

  ack_idle_a: assert property (
    !cfg_req.valid |=> !cfg_ack && cfg_rdata == 32'h0)
    else $error("acknowledge without access");

  amount_write_a: assert property (
    wr_gctl && !clr_soft && cfg_req.be[0]
      |=> gctl.min_power_amount == $past(cfg_req.wdata[7:0]))
    else $error("power amount write lost");

  devcap_clean_a: assert property (
    rd_devcap_s |=> cfg_rdata[31:12] == 20'h0)
    else $error("capability word carries stray bits");

  clock_run_a: assert property (
    !(in_d3 && gctl.d3_clock_stop) |=> sec_clk_run)
    else $error("secondary clocks stopped without cause");

  wake_idle_a: assert property (
    !l2_wake_req |=> !wake_out && !beacon_out)
    else $error("wake signalled without request");

  shallow_base_a: assert property (
    gctl.shallow_idle_exit_budget == 3'b001 |=> shallow_floor_ns == 17'd64)
    else $error("shallow band base wrong");

  shallow_top_a: assert property (
    gctl.shallow_idle_exit_budget == 3'b111 |=> shallow_floor_ns == 17'd4096)
    else $error("shallow top band wrong");

  deep_base_a: assert property (
    gctl.deep_idle_exit_budget == 3'b001 |=> deep_floor_ns == 17'd1000)
    else $error("deep band base wrong");

endmodule
`default_nettype wire

//--- tb/tb_bridge_general_control_low_bank.sv
// Self-checking bench for the bridge general control low bank
`timescale 1ns/1ps
`default_nettype none
`include "bgcl_params.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end

module tb_bridge_general_control_low_bank import bgcl_pkg::*; ;
  logic ref_clk, rstn, fund_reset_n, global_reset_pin, in_d3, l2_wake_req;
  bgcl_cfg_req_s cfg_req;
  logic cfg_ack, prefetch_inhibit, sec_clk_run, wake_out, beacon_out;
  logic [31:0] cfg_rdata;
  bgcl_power_s min_power;
  logic [16:0] shallow_floor_ns, deep_floor_ns;
  int n_errors, samples_checked;

  bgcl_bank i_dut (.ref_clk(ref_clk), .rstn(rstn), .fund_reset_n(fund_reset_n),
    .global_reset_pin(global_reset_pin), .cfg_req(cfg_req), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata), .in_d3(in_d3), .l2_wake_req(l2_wake_req),
    .prefetch_inhibit(prefetch_inhibit), .sec_clk_run(sec_clk_run), .wake_out(wake_out),
    .beacon_out(beacon_out), .min_power(min_power), .shallow_floor_ns(shallow_floor_ns),
    .deep_floor_ns(deep_floor_ns));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Lower bound of a band that doubles each step, code 0 has none
  function automatic logic [16:0] flr(input logic [16:0] base, input logic [2:0] c);
    return (c == 3'h0) ? 17'h00000 : base << (c - 3'h1);
  endfunction

  // One access: held for the taking edge, answer judged just after that edge
  task automatic cfg(input logic is_wr, input logic [11:0] a, input logic [3:0] ben,
      input logic [31:0] wd, output logic [31:0] r);
    @(posedge ref_clk);
    #1 cfg_req = '{valid: 1'b1, write: is_wr, addr: a, be: ben, wdata: wd};
    @(posedge ref_clk);
    #1 cfg_req.valid = 1'b0;
    `CHK("cfg_ack", 1'b1, cfg_ack)
    r = cfg_rdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] r;
    cfg(1'b1, a, be, d, r);
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    cfg(1'b0, a, 4'hf, 32'h0, r);
    `CHK(nm, e, r)
  endtask

  task automatic drv(input logic d3, input logic wk);
    @(posedge ref_clk);
    #1 in_d3 = d3;
    l2_wake_req = wk;
    @(posedge ref_clk);
    #1;
  endtask

  // Sync stages start cleared, so the bank needs a few edges before access
  task automatic do_reset();
    @(posedge ref_clk);
    #1 rstn = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 rstn = 1'b1;
    repeat (5) @(posedge ref_clk);
  endtask

  task automatic t_reset_vals();
    rdchk("gctl", `BGCL_OFF_GCTL, `BGCL_GCTL_RST);
    rdchk("vrsv", `BGCL_OFF_VRSV, 32'h00000000);
    wr(`BGCL_OFF_VRSV, 4'h1, 32'h00000000);
    rdchk("vrsv_kept", `BGCL_OFF_VRSV, 32'h00000000);
    rdchk("devcap", `BGCL_OFF_DEVCAP, 32'h00000d80);
    rdchk("aer", `BGCL_OFF_AER, 32'h00000000);
    rdchk("unmapped", 12'h0e0, 32'h00000000);
    `CHK("floor_s", 17'h00800, shallow_floor_ns)
    `CHK("floor_d", 17'h07d00, deep_floor_ns)
    `CHK("pf", 1'b0, prefetch_inhibit)
    `CHK("pwr", 10'h000, min_power)
  endtask

  // Every budget code, both prefetch and channel-structure states and every scale
  task automatic t_codes();
    logic [19:0] v;
    for (int c = 0; c < 8; c++) begin
      v = {c[0], c[2:0], 3'(7 - c), c[1], 2'b00, c[1:0], 8'(c * 37)};
      wr(`BGCL_OFF_GCTL, 4'hf, {12'h000, v});
      rdchk("devcap", `BGCL_OFF_DEVCAP, {20'h0, v[15:13], v[18:16], 6'h0});
      rdchk("aer", `BGCL_OFF_AER, {v[12] ? 12'h150 : 12'h000, 20'h0});
      rdchk("gctl", `BGCL_OFF_GCTL, {12'h820, v});
      `CHK("floor_s", flr(17'h00040, v[18:16]), shallow_floor_ns)
      `CHK("floor_d", flr(17'h003e8, v[15:13]), deep_floor_ns)
      `CHK("pf", v[19], prefetch_inhibit)
      `CHK("pwr", v[9:0], min_power)
    end
    wr(`BGCL_OFF_GCTL, 4'h1, 32'hffffffff);
    rdchk("lane0", `BGCL_OFF_GCTL, {12'h820, v[19:8], 8'hff});
  endtask

  // Write then read on the very next edge; the read must see the new codes
  task automatic t_back_to_back();
    @(posedge ref_clk);
    #1 cfg_req = '{valid: 1'b1, write: 1'b1, addr: `BGCL_OFF_GCTL, be: 4'hf,
      wdata: 32'h00032000};
    @(posedge ref_clk);
    #1 cfg_req = '{valid: 1'b1, write: 1'b0, addr: `BGCL_OFF_DEVCAP, be: 4'hf,
      wdata: 32'h00000000};
    `CHK("ack_wr", 1'b1, cfg_ack)
    @(posedge ref_clk);
    #1 cfg_req.valid = 1'b0;
    `CHK("ack_rd", 1'b1, cfg_ack)
    `CHK("devcap_b2b", 32'h000002c0, cfg_rdata)
  endtask

  task automatic t_bridge();
    wr(`BGCL_OFF_GCTL, 4'hf, 32'h0006c800);
    drv(1'b1, 1'b1);
    `CHK("sclk", 1'b0, sec_clk_run)
    `CHK("wake", 1'b1, wake_out)
    `CHK("beacon", 1'b0, beacon_out)
    wr(`BGCL_OFF_GCTL, 4'hf, 32'h0006c400);
    drv(1'b1, 1'b1);
    `CHK("sclk", 1'b1, sec_clk_run)
    `CHK("beacon", 1'b1, beacon_out)
    drv(1'b0, 1'b0);
    `CHK("beacon", 1'b0, beacon_out)
    `CHK("wake", 1'b0, wake_out)
  endtask

  // Pin resets clear the fields but must spare the two aux-powered bits
  task automatic t_sticky(input logic use_global);
    wr(`BGCL_OFF_GCTL, 4'hf, 32'h000a5c7f);
    @(posedge ref_clk);
    #1 global_reset_pin = use_global;
    fund_reset_n = use_global;
    repeat (6) @(posedge ref_clk);
    #1 global_reset_pin = 1'b0;
    fund_reset_n = 1'b1;
    repeat (6) @(posedge ref_clk);
    rdchk("gctl", `BGCL_OFF_GCTL, 32'h8206cc00);
    `CHK("pwr", 10'h000, min_power)
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #100us;
    n_errors++;
    print_verdict();
  end

  initial begin
    cfg_req = '0;
    rstn = 1'b0;
    fund_reset_n = 1'b1;
    global_reset_pin = 1'b0;
    in_d3 = 1'b0;
    l2_wake_req = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    do_reset();
    t_reset_vals();
    t_codes();
    t_back_to_back();
    t_bridge();
    t_sticky(1'b0);
    t_sticky(1'b1);
    do_reset();
    rdchk("gctl", `BGCL_OFF_GCTL, `BGCL_GCTL_RST);
    print_verdict();
  end
endmodule
`default_nettype wire
